// ==== ssrm_defines.svh ====
// constants for the state and special register move unit
`ifndef SSRM_DEFINES_SVH
`define SSRM_DEFINES_SVH

`define SSRM_OPC_PRIMARY 6'h1F
`define SSRM_XO_MTMSR 10'h092
`define SSRM_XO_MTMSRD 10'h0B2
`define SSRM_XO_MFMSR 10'h053
`define SSRM_XO_MTSPR 10'h1D3
`define SSRM_XO_MFSPR 10'h153
`define SSRM_MSR_RESET 64'h0000_0000_0000_0000
`define SSRM_MASK_W32 64'h0000_0000_FFFF_6FCF
`define SSRM_MASK_W64 64'h6FFF_FFFF_FFFF_6FCF
`define SSRM_MASK_PART 64'h0000_0000_0000_8002
`define SSRM_BIT_PR 49
`define SSRM_BIT_LE 63
`define SSRM_BIT_EE 48
`define SSRM_BIT_RI 62
`define SSRM_SPR_TBL 10'h11C
`define SSRM_SPR_TBU 10'h11D
`define SSRM_SPR_BASE 10'h110
`define SSRM_SPR_RESET 64'h0000_0000_0000_0000
`define SSRM_TB_RESET 64'h0000_0000_0000_0000

`endif

// ==== ssrm_pkg.sv ====
// types for the state and special register move unit
`default_nettype none
package ssrm_pkg;
  typedef enum logic [2:0] {
    SSRM_OP_NONE = 3'h0,
    SSRM_OP_MTMSR = 3'h1,
    SSRM_OP_MTMSRD = 3'h3,
    SSRM_OP_MFMSR = 3'h2,
    SSRM_OP_MTSPR = 3'h6,
    SSRM_OP_MFSPR = 3'h7
  } ssrm_op_type;

  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [0:63] data;
  } ssrm_wb_type;

  typedef struct packed {
    logic ctx_sync;
    logic exec_sync;
    logic le_unsynced;
  } ssrm_sync_type;
endpackage
`default_nettype wire

// ==== ssrm_unit.sv ====
// state and special register move execution unit
//
// Function
// - 32-bit state write, full: state 58 gets src 58 or 49, state 59 gets src 59 or 49.
// - 32-bit state write, full: src 32-47, 49-50, 52-57, 60-63 copied, upper half kept.
// - partial state write of either form copies only src 48 and 62, all else kept.
// - doubleword state write, full: state 0 gets src 0 or 1, state 59 gets src 59 or 49.
// - doubleword state write, full: src 1-2, 4-47, 49, 50, 52-57, 60-63 copied.
// - state writes and the state read run only at supervisor level.
// - a full state write is context synchronizing, except for the little-endian bit.
// - a partial state write is execution synchronizing, interrupt bits act at once.
// - the state read returns the whole state register to the destination.
// - a special write loads from the source, 32-bit registers take the low 32 bits.
// - timebase halves are written as separate 32-bit registers.
// - a special read returns the selected register to the destination.
// - the special number is rebuilt from two swapped 5-bit instruction halves.
`include "ssrm_defines.svh"
`default_nettype none
module ssrm_unit #(
  parameter int SPR_DEPTH = 8,
  parameter logic [7:0] SPR_NARROW = 8'h0F
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire logic [0:31] instr,
  input wire logic [0:63] source_gpr,
  output logic [0:63] machine_state_register,
  output logic [0:63] timebase,
  output ssrm_pkg::ssrm_wb_type wb,
  output ssrm_pkg::ssrm_sync_type sync,
  output logic priv_fault
);
  import ssrm_pkg::*;

  logic [0:63] msr_ff, nxt_msr;
  logic [0:63] tb_ff, nxt_tb;
  logic [0:63] spr_ff [SPR_DEPTH];
  ssrm_wb_type wb_ff, nxt_wb;
  ssrm_sync_type sync_ff, nxt_sync;
  logic fault_ff;

  // field decode
  wire logic [5:0] opc = instr[0:5];
  wire logic [9:0] xo = instr[21:30];
  wire logic [4:0] reg_idx = instr[6:10];
  wire logic part_flag = instr[15];
  wire logic [9:0] special_register_number = {instr[16:20], instr[11:15]};

  wire logic is_x = issue_valid && (opc == `SSRM_OPC_PRIMARY);
  wire ssrm_op_type op = !is_x ? SSRM_OP_NONE :
    (xo == `SSRM_XO_MTMSR) ? SSRM_OP_MTMSR :
    (xo == `SSRM_XO_MTMSRD) ? SSRM_OP_MTMSRD :
    (xo == `SSRM_XO_MFMSR) ? SSRM_OP_MFMSR :
    (xo == `SSRM_XO_MTSPR) ? SSRM_OP_MTSPR :
    (xo == `SSRM_XO_MFSPR) ? SSRM_OP_MFSPR : SSRM_OP_NONE;

  wire logic user_mode = msr_ff[`SSRM_BIT_PR];
  wire logic msr_op = (op == SSRM_OP_MTMSR) || (op == SSRM_OP_MTMSRD) ||
    (op == SSRM_OP_MFMSR);
  wire logic fault = msr_op && user_mode;
  wire logic do_w32 = (op == SSRM_OP_MTMSR) && !user_mode;
  wire logic do_w64 = (op == SSRM_OP_MTMSRD) && !user_mode;
  wire logic do_rd = (op == SSRM_OP_MFMSR) && !user_mode;
  wire logic do_part = (do_w32 || do_w64) && part_flag;
  wire logic do_full32 = do_w32 && !part_flag;
  wire logic do_full64 = do_w64 && !part_flag;

  wire logic [0:63] msr_mask = do_part ? `SSRM_MASK_PART :
    do_full32 ? `SSRM_MASK_W32 : do_full64 ? `SSRM_MASK_W64 : 64'h0;
  wire logic [0:63] msr_copy = (msr_ff & ~msr_mask) | (source_gpr & msr_mask);

  // state register next value
  always_comb begin
    nxt_msr = msr_copy;
    if (do_full32) begin
      nxt_msr[58] = source_gpr[58] | source_gpr[49];
      nxt_msr[59] = source_gpr[59] | source_gpr[49];
    end
    if (do_full64) begin
      nxt_msr[0] = source_gpr[0] | source_gpr[1];
      nxt_msr[59] = source_gpr[59] | source_gpr[49];
    end
  end

  // special register access
  wire logic do_mtspr = (op == SSRM_OP_MTSPR);
  wire logic do_mfspr = (op == SSRM_OP_MFSPR);
  wire logic hit_tbl = special_register_number == `SSRM_SPR_TBL;
  wire logic hit_tbu = special_register_number == `SSRM_SPR_TBU;
  wire logic [9:0] spr_off = special_register_number - `SSRM_SPR_BASE;
  wire logic hit_file = (special_register_number >= `SSRM_SPR_BASE) &&
    (spr_off < 10'(SPR_DEPTH));
  wire logic [2:0] spr_idx = spr_off[2:0];
  wire logic [0:63] narrow_src = {32'h0000_0000, source_gpr[32:63]};
  wire logic [0:63] spr_rd = !hit_file ? 64'h0 : spr_ff[spr_idx];
  wire logic [0:63] mfspr_data = hit_tbl ? {32'h0000_0000, tb_ff[32:63]} :
    hit_tbu ? {32'h0000_0000, tb_ff[0:31]} : spr_rd;

  always_comb begin
    nxt_tb = tb_ff + 64'h1;
    if (do_mtspr && hit_tbl) begin
      nxt_tb = {tb_ff[0:31], source_gpr[32:63]};
    end else if (do_mtspr && hit_tbu) begin
      nxt_tb = {source_gpr[32:63], tb_ff[32:63]};
    end
  end

  for (genvar i = 0; i < SPR_DEPTH; i++) begin : g_spr
    wire logic wr = do_mtspr && hit_file && (spr_idx == 3'(i));
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        spr_ff[i] <= `SSRM_SPR_RESET;
      end else if (wr) begin
        spr_ff[i] <= SPR_NARROW[i] ? narrow_src : source_gpr;
      end
    end
  end

  // write-back selection
  always_comb begin
    nxt_wb.valid = do_rd || do_mfspr;
    nxt_wb.idx = reg_idx;
    nxt_wb.data = do_rd ? msr_ff : do_mfspr ? mfspr_data : 64'h0;
    nxt_sync.ctx_sync = do_full32 || do_full64;
    nxt_sync.le_unsynced = (do_full32 || do_full64) &&
      (nxt_msr[`SSRM_BIT_LE] != msr_ff[`SSRM_BIT_LE]);
    nxt_sync.exec_sync = do_part;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      msr_ff <= `SSRM_MSR_RESET;
      tb_ff <= `SSRM_TB_RESET;
      wb_ff <= '0;
      sync_ff <= '0;
      fault_ff <= 1'b0;
    end else begin
      msr_ff <= nxt_msr;
      tb_ff <= nxt_tb;
      wb_ff <= nxt_wb;
      sync_ff <= nxt_sync;
      fault_ff <= fault;
    end
  end

  assign machine_state_register = msr_ff;
  assign timebase = tb_ff;
  assign wb = wb_ff;
  assign sync = sync_ff;
  assign priv_fault = fault_ff;

  // checking helpers
  logic [0:63] src_prev_ff, msr_prev_ff, tb_prev_ff;
  always_ff @(posedge clk_sys) begin
    src_prev_ff <= source_gpr;
    msr_prev_ff <= msr_ff;
    tb_prev_ff <= tb_ff;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_w32_or;
    do_full32 |=> msr_ff[58] == (src_prev_ff[58] | src_prev_ff[49]) &&
      msr_ff[59] == (src_prev_ff[59] | src_prev_ff[49]);
  endproperty
  a_w32_or: assert property (p_w32_or) else $error("w32 ored bits wrong");
  property p_w32_copy;
    do_full32 |=> msr_ff[0:31] == msr_prev_ff[0:31] &&
      msr_ff[32:47] == src_prev_ff[32:47] && msr_ff[60:63] == src_prev_ff[60:63];
  endproperty
  a_w32_copy: assert property (p_w32_copy) else $error("w32 copy wrong");
  property p_part;
    do_part |=> (msr_ff & ~`SSRM_MASK_PART) == (msr_prev_ff & ~`SSRM_MASK_PART) &&
      msr_ff[48] == src_prev_ff[48] && msr_ff[62] == src_prev_ff[62];
  endproperty
  a_part: assert property (p_part) else $error("partial write wrong");
  property p_w64_or;
    do_full64 |=> msr_ff[0] == (src_prev_ff[0] | src_prev_ff[1]) &&
      msr_ff[59] == (src_prev_ff[59] | src_prev_ff[49]);
  endproperty
  a_w64_or: assert property (p_w64_or) else $error("w64 ored bits wrong");
  property p_w64_copy;
    do_full64 |=> msr_ff[4:47] == src_prev_ff[4:47] && msr_ff[3] == msr_prev_ff[3] &&
      msr_ff[1:2] == src_prev_ff[1:2] && msr_ff[60:63] == src_prev_ff[60:63];
  endproperty
  a_w64_copy: assert property (p_w64_copy) else $error("w64 copy wrong");
  property p_fault;
    fault |=> priv_fault && !wb_ff.valid && $stable(msr_ff);
  endproperty
  a_fault: assert property (p_fault) else $error("user state move not blocked");
  property p_priv;
    msr_op && !user_mode |=> !priv_fault;
  endproperty
  a_priv: assert property (p_priv) else $error("supervisor move faulted");
  property p_ctx;
    (do_full32 || do_full64) |=> sync_ff.ctx_sync && !sync_ff.exec_sync;
  endproperty
  a_ctx: assert property (p_ctx) else $error("no context sync");
  property p_exec;
    do_part |=> sync_ff.exec_sync ##1 (!sync_ff.exec_sync || $past(do_part));
  endproperty
  a_exec: assert property (p_exec) else $error("no execution sync");
  property p_mfmsr;
    do_rd |=> wb_ff.valid && wb_ff.data == msr_prev_ff;
  endproperty
  a_mfmsr: assert property (p_mfmsr) else $error("state read data wrong");
  property p_tbl;
    do_mtspr && hit_tbl |=> timebase[0:31] == tb_prev_ff[0:31] &&
      timebase[32:63] == src_prev_ff[32:63];
  endproperty
  a_tbl: assert property (p_tbl) else $error("timebase lower write wrong");
  property p_tb_run;
    !(do_mtspr && (hit_tbl || hit_tbu)) |=> timebase == tb_prev_ff + 64'h1;
  endproperty
  a_tb_run: assert property (p_tb_run) else $error("timebase did not count");
  property p_spr_rt;
    do_mtspr && hit_file ##1 do_mfspr && hit_file && $stable(spr_idx)
      |=> wb_ff.data[32:63] == $past(src_prev_ff[32:63], 1);
  endproperty
  a_spr_rt: assert property (p_spr_rt) else $error("special round trip wrong");
  property p_sprn;
    do_mtspr && hit_tbl |-> instr[16:20] == 5'h08 && instr[11:15] == 5'h1C;
  endproperty
  a_sprn: assert property (p_sprn) else $error("special number decode wrong");
  property p_mfspr;
    do_mfspr |=> wb_ff.valid && wb_ff.idx == $past(reg_idx);
  endproperty
  a_mfspr: assert property (p_mfspr) else $error("special read missing");

  c_full: cover property (do_full32 ##1 do_rd);
  c_part: cover property (do_part);
  c_fault: cover property (fault);
  c_tbu: cover property (do_mtspr && hit_tbu);
endmodule
`default_nettype wire

// ==== ssrm_unit_tb.sv ====
// self-checking bench for the state and special register move unit
`include "ssrm_defines.svh"
`default_nettype none
module ssrm_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ssrm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic issue_valid = 1'b0;
  logic [0:31] instr = 32'h0000_0000;
  logic [0:63] source_gpr = 64'h0;
  logic [0:63] machine_state_register, timebase, tb_pre, msr_m, e, v;
  logic [9:0] num;
  ssrm_wb_type wb;
  ssrm_sync_type sync;
  logic priv_fault;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [0:63] ws [5] = '{64'hFFFF_FFFF_0000_0021, 64'hC000_0000_1234_0010,
    64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 64'h0000_0000_0000_4000};

  always #5 clk_sys = ~clk_sys;

  ssrm_unit DUT (.clk_sys(clk_sys), .rst_n(rst_n), .issue_valid(issue_valid), .instr(instr),
    .source_gpr(source_gpr), .machine_state_register(machine_state_register),
    .timebase(timebase), .wb(wb), .sync(sync), .priv_fault(priv_fault));

  function automatic logic [0:31] enc(logic [9:0] xo, logic [4:0] r, logic [9:0] n);
    return {6'h1F, r, n[4:0], n[9:5], xo, 1'b0};
  endfunction

  function automatic logic [0:63] exp_msr(logic [0:63] o, logic [0:63] s, logic dw, logic l);
    logic [0:63] n;
    n = o;
    if (l) begin
      n[48] = s[48];
      n[62] = s[62];
    end else begin
      n[32:47] = s[32:47];
      n[49:50] = s[49:50];
      n[52:57] = s[52:57];
      n[60:63] = s[60:63];
      n[59] = s[59] | s[49];
      if (dw) begin
        n[0] = s[0] | s[1];
        n[1:2] = s[1:2];
        n[4:31] = s[4:31];
      end else n[58] = s[58] | s[49];
    end
    return n;
  endfunction

  task automatic chk(logic [0:63] got, logic [0:63] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic op(logic [0:31] i, logic [0:63] s);
    issue_valid = 1'b1;
    instr = i;
    source_gpr = s;
    tb_pre = timebase;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    issue_valid = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    msr_m = 64'h0;
  endtask

  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end

  initial begin
    @(posedge clk_sys);
    #1;
    do_reset();
    chk(machine_state_register, 64'h0);
    // state writes in alternate cycles, each but the last read back in the next cycle
    for (int k = 0; k < 5; k++) begin
      e = exp_msr(msr_m, ws[k], k[0], k[1]);
      op(enc(k[0] ? `SSRM_XO_MTMSRD : `SSRM_XO_MTMSR, 5'h0, {9'h0, k[1]}), ws[k]);
      chk(machine_state_register, e);
      chk(64'(sync), 64'({~k[1], k[1], msr_m[63] ^ e[63]}));
      msr_m = e;
      if (k < 4) begin
        op(enc(`SSRM_XO_MFMSR, 5'h3, 10'h0), 64'h0);
        chk(64'({wb.valid, wb.idx}), 64'h23);
        chk(wb.data, msr_m);
      end
    end
    // user level now: every state move refused
    for (int k = 0; k < 3; k++) begin
      op(enc(k == 0 ? `SSRM_XO_MTMSR : k == 1 ? `SSRM_XO_MTMSRD : `SSRM_XO_MFMSR, 5'h1,
        10'h0), 64'hFFFF_FFFF_FFFF_FFFF);
      chk(64'({priv_fault, wb.valid}), 64'h2);
      chk(machine_state_register, msr_m);
    end
    // special file, narrow and wide entries, one unmapped number
    for (int i = 0; i < 9; i++) begin
      num = (i < 8) ? 10'(`SSRM_SPR_BASE + i) : 10'h120;
      op(enc(`SSRM_XO_MTSPR, 5'h2, num), 64'h0123_4567_89AB_CDEF + 64'(i));
    end
    for (int i = 0; i < 9; i++) begin
      num = (i < 8) ? 10'(`SSRM_SPR_BASE + i) : 10'h120;
      v = 64'h0123_4567_89AB_CDEF + 64'(i);
      e = (i == 8) ? 64'h0 : (i < 4) ? {32'h0, v[32:63]} : v;
      op(enc(`SSRM_XO_MFSPR, 5'(i), num), 64'h0);
      chk(64'({wb.valid, wb.idx}), 64'(6'h20 + i));
      chk(wb.data, e);
    end
    // timebase halves
    op(enc(`SSRM_XO_MTSPR, 5'h0, `SSRM_SPR_TBL), 64'hAAAA_AAAA_1234_5678);
    chk(timebase, {tb_pre[0:31], 32'h1234_5678});
    op(enc(`SSRM_XO_MTSPR, 5'h0, `SSRM_SPR_TBU), 64'h5555_5555_0000_00FF);
    chk(timebase, {32'h0000_00FF, tb_pre[32:63]});
    op(enc(`SSRM_XO_MFSPR, 5'h4, `SSRM_SPR_TBL), 64'h0);
    chk(wb.data, {32'h0, tb_pre[32:63]});
    chk(timebase, tb_pre + 64'h1);
    op(enc(`SSRM_XO_MFSPR, 5'h5, `SSRM_SPR_TBU), 64'h0);
    chk(wb.data, {32'h0, tb_pre[0:31]});
    // wide entry written then read at once
    op(enc(`SSRM_XO_MTSPR, 5'h0, 10'h115), 64'hFEDC_BA98_7654_3210);
    op(enc(`SSRM_XO_MFSPR, 5'h6, 10'h115), 64'h0);
    chk(wb.data, 64'hFEDC_BA98_7654_3210);
    // unknown extended opcode ignored
    op(enc(10'h000, 5'h1, 10'h0), 64'hFFFF_FFFF_FFFF_FFFF);
    chk(64'({priv_fault, wb.valid, sync}), 64'h0);
    do_reset();
    chk(machine_state_register, 64'h0);
    chk(timebase, 64'h0);
    test_done();
  end
endmodule
`default_nettype wire
